// [hdl/adp_pkg.sv]
// Package of constants for the addressable dual-port I/O byte
package adp_pkg;
	localparam int           DATA_W          = 8;
	localparam logic [7:0]   USER_RESET_VAL  = 8'hff;
	localparam logic [7:0]   LATCH_RESET_VAL = 8'h00;
	localparam logic [7:0]   DEFAULT_ADDR    = 8'hff;
	localparam logic         SEL_RESET_VAL   = 1'b0;
	localparam int           SYNC_STAGES     = 2;
endpackage

// [hdl/adp_sync.sv]
// Two-flop synchroniser bank for pin inputs
module adp_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule

// [hdl/adp_io_byte.sv]
// Addressable dual-port I/O byte: host vector port and user data port
module adp_io_byte #(
	parameter logic [7:0] ADDRESS        = adp_pkg::DEFAULT_ADDR,
	parameter bit         ASYNC_USER     = 1'b0,
	parameter bit         OPEN_COLLECTOR = 1'b0
) (
	input  wire logic       I_SYS_CLK,
	input  wire logic       I_ARST_N,
	input  wire logic       I_MASTER_CLK,
	input  wire logic       I_HOST_PORT_GATE_N,
	input  wire logic       I_HOST_SELECT_STROBE,
	input  wire logic       I_HOST_WRITE_STROBE,
	input  wire logic       I_USER_INPUT_STROBE_N,
	input  wire logic       I_USER_OUTPUT_ENABLE_N,
	input  wire logic [7:0] I_HOST_VECTOR_LINES_N,
	output logic      [7:0] O_HOST_VECTOR_LINES_N,
	output logic      [7:0] O_HOST_VECTOR_LINES_OE,
	input  wire logic [7:0] I_USER_DATA_LINES,
	output logic      [7:0] O_USER_DATA_LINES,
	output logic      [7:0] O_USER_DATA_LINES_OE,
	output logic            O_SELECTED
);
	localparam int W = adp_pkg::DATA_W;
	localparam int CW = 6;

	// ********************************
	// Input synchronisers
	// ********************************
	logic [CW-1:0] ctl_raw;
	logic [CW-1:0] ctl;
	logic [W-1:0]  host_in_n;
	logic [W-1:0]  user_in;

	// Active-low controls enter inverted so a cleared synchroniser reads as idle
	assign ctl_raw = {I_MASTER_CLK, !I_HOST_PORT_GATE_N, I_HOST_SELECT_STROBE, I_HOST_WRITE_STROBE,
		!I_USER_INPUT_STROBE_N, !I_USER_OUTPUT_ENABLE_N};

	adp_sync #(.W(CW)) u_sync_ctl (
		.clk    (I_SYS_CLK),
		.arst_n (I_ARST_N),
		.d      (ctl_raw),
		.q      (ctl)
	);

	adp_sync #(.W(W)) u_sync_host (
		.clk    (I_SYS_CLK),
		.arst_n (I_ARST_N),
		.d      (I_HOST_VECTOR_LINES_N),
		.q      (host_in_n)
	);

	adp_sync #(.W(W)) u_sync_user (
		.clk    (I_SYS_CLK),
		.arst_n (I_ARST_N),
		.d      (I_USER_DATA_LINES),
		.q      (user_in)
	);

	logic mclk;
	logic gate_n;
	logic sel_s;
	logic wr_s;
	logic uin_n;
	logic uoe_n;

	always_comb begin
		mclk   = ctl[5];
		gate_n = !ctl[4];
		sel_s  = ctl[3];
		wr_s   = ctl[2];
		uin_n  = !ctl[1];
		uoe_n  = !ctl[0];
	end

	// ********************************
	// Decode of host and user operations
	// ********************************
	logic host_on;
	logic addr_cycle;
	logic host_wr;
	logic host_rd;
	logic user_wr;
	logic addr_match;
	logic user_drive;
	logic selected;
	logic next_selected;

	// Latches hold user-side polarity; host bus is active low, so it maps straight through
	always_comb begin
		host_on    = !gate_n;
		addr_match = (~host_in_n == ADDRESS);
		addr_cycle = host_on && sel_s && mclk;
		host_wr    = host_on && wr_s && mclk && uin_n && (sel_s || selected);
		host_rd    = host_on && !sel_s && !wr_s && selected;
		user_wr    = !uin_n && (ASYNC_USER || mclk);
		user_drive = !uoe_n && uin_n;
	end

	// ********************************
	// Data latches and select status
	// ********************************
	logic [W-1:0] latch;
	logic [W-1:0] next_latch;

	always_comb begin
		next_latch    = latch;
		next_selected = selected;
		if (user_wr) begin
			next_latch = user_in;
		end else if (host_wr) begin
			// Stored plain from host: reads back unchanged on the user side
			next_latch = host_in_n;
		end
		if (addr_cycle) begin
			next_selected = addr_match;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			latch    <= adp_pkg::USER_RESET_VAL;
			selected <= adp_pkg::SEL_RESET_VAL;
		end else begin
			latch    <= next_latch;
			selected <= next_selected;
		end
	end

	// ********************************
	// Output drivers
	// ********************************
	logic [W-1:0] next_user_out;
	logic [W-1:0] next_user_oe;
	logic [W-1:0] next_host_out;
	logic [W-1:0] next_host_oe;

	always_comb begin
		next_host_out = latch;
		next_host_oe  = {W{host_rd}};
		next_user_out = latch;
		next_user_oe  = {W{user_drive}};
	end

	// Open collector: pull low only, released high
	genvar b;
	logic [W-1:0] uo_oe_bit;
	logic [W-1:0] uo_val_bit;
	generate
		for (b = 0; b < W; b++) begin : g_ud
			always_comb begin
				if (OPEN_COLLECTOR) begin
					uo_val_bit[b] = 1'b0;
					uo_oe_bit[b]  = next_user_oe[b] && !next_user_out[b];
				end else begin
					uo_val_bit[b] = next_user_out[b];
					uo_oe_bit[b]  = next_user_oe[b];
				end
			end
		end
	endgenerate

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_HOST_VECTOR_LINES_N  <= '0;
			O_HOST_VECTOR_LINES_OE <= '0;
			O_USER_DATA_LINES      <= adp_pkg::USER_RESET_VAL;
			O_USER_DATA_LINES_OE   <= '0;
			O_SELECTED             <= adp_pkg::SEL_RESET_VAL;
		end else begin
			O_HOST_VECTOR_LINES_N  <= next_host_out;
			O_HOST_VECTOR_LINES_OE <= next_host_oe;
			O_USER_DATA_LINES      <= uo_val_bit;
			O_USER_DATA_LINES_OE   <= uo_oe_bit;
			O_SELECTED             <= next_selected;
		end
	end
endmodule

// [sim/adp_io_byte_checker.sv]
// Port checker for the addressable I/O byte
module adp_io_byte_checker (
	input wire logic       I_SYS_CLK,
	input wire logic       I_ARST_N,
	input wire logic       I_MASTER_CLK,
	input wire logic       I_HOST_PORT_GATE_N,
	input wire logic       I_HOST_SELECT_STROBE,
	input wire logic       I_HOST_WRITE_STROBE,
	input wire logic       I_USER_INPUT_STROBE_N,
	input wire logic       I_USER_OUTPUT_ENABLE_N,
	input wire logic [7:0] O_HOST_VECTOR_LINES_OE,
	input wire logic [7:0] O_USER_DATA_LINES_OE,
	input wire logic       O_SELECTED
);
	timeunit 1ns;
	timeprecision 1ns;
	wire       g = I_HOST_PORT_GATE_N;
	wire       s = I_HOST_SELECT_STROBE;
	wire       w = I_HOST_WRITE_STROBE;
	wire       ui = I_USER_INPUT_STROBE_N;
	wire       uo = I_USER_OUTPUT_ENABLE_N;
	wire       se = O_SELECTED;
	wire [7:0] ho = O_HOST_VECTOR_LINES_OE;
	wire [7:0] uq = O_USER_DATA_LINES_OE;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_ARST_N);
	a_gate_host_off: assert property (g [*6] |-> ho == 8'h00) else $error("gate");
	a_host_read_drive: assert property ((!g && !s && !w && se) [*6] |-> ho == 8'hff) else $error("read");
	a_strobe_host_off: assert property ((s || w) [*6] |-> ho == 8'h00) else $error("strobe");
	a_unsel_host_off: assert property ((!se) [*6] |-> ho == 8'h00) else $error("unsel");
	a_user_drive_on: assert property ((ui && !uo) [*6] |-> uq == 8'hff) else $error("udrive");
	a_user_bus_idle: assert property ((ui && uo) [*6] |-> uq == 8'h00) else $error("uidle");
	a_user_input_off: assert property ((!ui) [*6] |-> uq == 8'h00) else $error("uin");
	a_select_hold: assert property ((g || !s || !I_MASTER_CLK) [*6] |-> $stable(se)) else $error("sel");
	c_selected: cover property ($rose(se));
	c_host_read: cover property (ho == 8'hff);
	c_user_read: cover property (uq == 8'hff);
endmodule
bind adp_io_byte adp_io_byte_checker i_chk (.*);

// [sim/adp_host_model.sv]
// Controller model: strobes and host bus
module adp_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] dut_n,
	input  wire logic [7:0] dut_oe,
	output logic            gate_n,
	output logic            sel,
	output logic            wr,
	output logic            mclk,
	output logic [7:0]      bus_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] drv_n = 8'h00;
	logic       own = 1'b0;
	// Released lines show the inverse of the last byte
	assign bus_n = (dut_oe & dut_n) | (~dut_oe & (own ? drv_n : ~drv_n));
	initial {gate_n, sel, wr, mclk} = 4'b1000;
	// Caller is already at a falling edge, so host and user pins move together
	task automatic cyc(input logic [3:0] c, input logic [7:0] v);
		{gate_n, sel, wr, mclk} = c;
		own = c[2] | c[1];
		drv_n = own ? v : drv_n;
		repeat (6) @(negedge clk);
	endtask
endmodule

// [sim/adp_io_byte_test.sv]
// Self-checking bench for the addressable I/O byte
module adp_io_byte_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ADDR = 8'h5a;
	logic       clk, arst_n, ui, uo, g, s, w, m, se;
	logic [7:0] ud, hv, ho, hoe, uq, uoe;
	int         n_errors = 0;
	int         n_tests = 0;
	adp_io_byte #(.ADDRESS(ADDR)) i_dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_MASTER_CLK(m),
		.I_HOST_PORT_GATE_N(g), .I_HOST_SELECT_STROBE(s), .I_HOST_WRITE_STROBE(w),
		.I_USER_INPUT_STROBE_N(ui), .I_USER_OUTPUT_ENABLE_N(uo), .I_HOST_VECTOR_LINES_N(hv),
		.O_HOST_VECTOR_LINES_N(ho), .O_HOST_VECTOR_LINES_OE(hoe), .I_USER_DATA_LINES(ud),
		.O_USER_DATA_LINES(uq), .O_USER_DATA_LINES_OE(uoe), .O_SELECTED(se));
	adp_host_model i_host (.clk(clk), .dut_n(ho), .dut_oe(hoe), .gate_n(g), .sel(s), .wr(w), .mclk(m), .bus_n(hv));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [7:0] a, input logic [7:0] e);
		n_tests++;
		if (a !== e) begin
			n_errors++;
			$display("mismatch %0t seen %h expected %h", $time, a, e);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// User controls and data, then one held host cycle
	task automatic step(input logic [1:0] u, input logic [7:0] d, input logic [3:0] c, input logic [7:0] v);
		@(negedge clk);
		{ui, uo, ud} = {u, d};
		i_host.cyc(c, v);
	endtask
	task automatic t_reset;
		check(uq, 8'hff);
		check(uoe | hoe, 8'h00);
		check({7'h00, se}, 8'h00);
		$display("t_reset end");
	endtask
	task automatic t_select;
		step(2'b11, 8'h00, 4'b0101, ~ADDR);
		check({7'h00, se}, 8'h01);
		step(2'b11, 8'h00, 4'b0101, ~ADDR ^ 8'h80);
		check({7'h00, se}, 8'h00);
		step(2'b11, 8'h00, 4'b0000, 8'h00);
		check(hoe, 8'h00);
		step(2'b11, 8'h00, 4'b0101, ~ADDR);
		$display("t_select end");
	endtask
	task automatic t_data;
		step(2'b11, 8'h00, 4'b0011, 8'h3c);
		step(2'b10, 8'h00, 4'b0000, 8'h00);
		check(uq, 8'h3c);
		check(hoe, 8'hff);
		check(ho, 8'h3c);
		step(2'b01, 8'ha5, 4'b1000, 8'h00);
		step(2'b10, 8'h00, 4'b1000, 8'h00);
		check(uq, 8'h3c);
		step(2'b01, 8'ha5, 4'b1001, 8'h00);
		step(2'b11, 8'h00, 4'b0000, 8'h00);
		check(ho, 8'ha5);
		step(2'b01, 8'h0f, 4'b0011, 8'hf0);
		step(2'b10, 8'h00, 4'b1011, 8'h11);
		check(uq, 8'h0f);
		step(2'b10, 8'h00, 4'b0111, 8'h77);
		check(uq, 8'h77);
		check({7'h00, se}, 8'h00);
		$display("t_data end");
	endtask
	initial begin
		{arst_n, ui, uo, ud} = {3'b011, 8'h00};
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reset;
		t_select;
		t_data;
		test_done;
	end
	initial begin
		#20000;
		n_errors++;
		test_done;
	end
endmodule
